//--- hw/dcnt_top.sv
// Link diagnostics: loopback routing, crossover and polarity status, statistics counters,
// interrupt, all behind an APB slave.
// Assumes every input is synchronous to I_SYS_CLK and event inputs are one-cycle pulses.
`default_nettype none
`include "dcnt_regs.svh"
module dcnt_top (
  input  wire logic              I_SYS_CLK,
  input  wire logic              I_ARST_N,
  input  wire logic              I_PSEL,
  input  wire logic              I_PENABLE,
  input  wire logic              I_PWRITE,
  input  wire dcnt_pkg::dcnt_addr_t I_PADDR,
  input  wire dcnt_pkg::dcnt_data_t I_PWDATA,
  output var  dcnt_pkg::dcnt_data_t O_PRDATA,
  output var  logic              O_PREADY,
  output var  logic              O_PSLVERR,
  input  wire logic [7:0]        I_SCR_TX_DATA,
  input  wire logic              I_TX_VALID,
  input  wire logic [7:0]        I_LINE_RX_DATA,
  output var  logic [7:0]        O_LINE_TX_DATA,
  output var  logic              O_LINE_TX_EN,
  output var  logic              O_TX_PWR_EN,
  output var  logic [7:0]        O_DESCR_RX_DATA,
  input  wire logic              I_LINK_UP,
  input  wire logic              I_AN_DONE,
  input  wire logic              I_CROSSOVER_PAIR_A_RESULT,
  input  wire logic              I_CROSSOVER_PAIR_B_RESULT,
  input  wire logic [3:0]        I_CHAN_POL_DETECT,
  output var  logic [3:0]        O_POL_CORRECT,
  input  wire logic              I_GOOD_PKT,
  input  wire logic              I_CRC_ERR,
  input  wire logic              I_TX_PKT,
  input  wire logic              I_RXERR_DATA,
  input  wire logic              I_RXERR_IDLE,
  output var  logic              O_IRQ
);
  import dcnt_pkg::*;

  // Whole state of the block in one record.
  typedef struct packed {
    dcnt_apb_st_t apb_st;
    logic         apb_err;
    dcnt_data_t   prdata;
    logic         loopback;
    logic [3:0]   irq_mask;
    logic [3:0]   irq_stat;
    logic         irq;
    logic         link_up;
    logic         an_done;
    logic         crossover_pair_a_result;
    logic         crossover_pair_b_result;
    logic         chan3_inverted_flag;
    logic         chan2_inverted_flag;
    logic         chan1_inverted_flag;
    logic         chan0_inverted_flag;
    dcnt_idx_t    adv_idx;
    dcnt_word_t   rxerr_data;
    dcnt_word_t   rxerr_idle;
    logic [7:0]   line_tx;
    logic         line_tx_en;
    logic         tx_pwr_en;
    logic [7:0]   descr_rx;
  } dcnt_top_st_t;

  dcnt_top_st_t st_ff;
  dcnt_top_st_t nxt_st;

  // Counter slices: 0 good packets, 1 CRC errors, 2 transmitted packets.
  logic [2:0]  ctr_inc;
  wire logic [2:0] ctr_rd_lo;
  wire logic [2:0] ctr_rd_hi;
  wire dcnt_word_t ctr_lo  [3];
  wire dcnt_word_t ctr_mid [3];
  wire dcnt_word_t ctr_hi  [3];
  logic        adv_rd;
  logic        setup;
  logic        acc_done;
  logic        wr_en;
  logic [3:0]  pol_now;
  logic [3:0]  pol_old;
  logic [3:0]  irq_ev;
  logic [3:0]  irq_clr;

  // Index of the low word of a counter slice.
  function automatic dcnt_idx_t ctr_base(input int k);
    case (k)
      0:       ctr_base = `DCNT_IDX_GOOD_LO;
      1:       ctr_base = `DCNT_IDX_CRC_LO;
      default: ctr_base = `DCNT_IDX_TX_LO;
    endcase
  endfunction : ctr_base

  // True for the byte offsets that this slave answers.
  function automatic logic is_mapped(input dcnt_addr_t a);
    case (a)
      `DCNT_OFF_CTRL, `DCNT_OFF_STAT, `DCNT_OFF_IRQ_STAT,
      `DCNT_OFF_IRQ_MASK, `DCNT_OFF_ADV_ADDR, `DCNT_OFF_ADV_DATA: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  assign ctr_inc = {I_TX_PKT, I_CRC_ERR, I_GOOD_PKT};

  // Each slice is strobed when its low or high word is read through the data port.
  for (genvar k = 0; k < 3; k++) begin : g_ctr
    dcnt_ctr_if u_if ();
    assign u_if.inc   = ctr_inc[k];
    assign u_if.rd_lo = ctr_rd_lo[k];
    assign u_if.rd_hi = ctr_rd_hi[k];
    assign ctr_lo[k]  = u_if.lo;
    assign ctr_mid[k] = u_if.mid;
    assign ctr_hi[k]  = u_if.hi;
    assign ctr_rd_lo[k] = adv_rd && (st_ff.adv_idx == ctr_base(k));
    assign ctr_rd_hi[k] = adv_rd &&
                          (st_ff.adv_idx == ctr_base(k) + `DCNT_IDX_HI_STEP);
    dcnt_ctr48 u_ctr (
      .i_clk    (I_SYS_CLK),
      .i_arst_n (I_ARST_N),
      .bus      (u_if)
    );
  end

  // Bus phases: side effects of reads happen in the setup cycle, writes at completion.
  assign setup    = I_PSEL && !I_PENABLE;
  assign acc_done = I_PSEL && I_PENABLE && (st_ff.apb_st == DCNT_ST_RESP);
  assign wr_en    = acc_done && I_PWRITE && !st_ff.apb_err;
  assign adv_rd   = setup && !I_PWRITE && (I_PADDR == `DCNT_OFF_ADV_DATA);

  // Event detection for the interrupt status.
  assign pol_now = I_CHAN_POL_DETECT;
  assign pol_old = {st_ff.chan3_inverted_flag, st_ff.chan2_inverted_flag,
                    st_ff.chan1_inverted_flag, st_ff.chan0_inverted_flag};
  always_comb begin
    irq_ev = 4'h0;
    irq_ev[`DCNT_EV_LINK]   = I_LINK_UP != st_ff.link_up;
    irq_ev[`DCNT_EV_ANDONE] = I_AN_DONE && !st_ff.an_done;
    irq_ev[`DCNT_EV_XOVER]  = (I_CROSSOVER_PAIR_A_RESULT != st_ff.crossover_pair_a_result) ||
                              (I_CROSSOVER_PAIR_B_RESULT != st_ff.crossover_pair_b_result);
    irq_ev[`DCNT_EV_POL]    = pol_now != pol_old;
    irq_clr = (wr_en && (I_PADDR == `DCNT_OFF_IRQ_STAT)) ? I_PWDATA[3:0] : 4'h0;
  end

  // Read data of the indirect counter word selected by the address port.
  function automatic dcnt_word_t adv_word(input dcnt_idx_t idx);
    adv_word = 16'h0000;
    for (int k = 0; k < 3; k++) begin
      if (idx == ctr_base(k)) begin
        adv_word = ctr_lo[k];
      end
      if (idx == ctr_base(k) + `DCNT_IDX_MID_STEP) begin
        adv_word = ctr_mid[k];
      end
      if (idx == ctr_base(k) + `DCNT_IDX_HI_STEP) begin
        adv_word = ctr_hi[k];
      end
    end
    if (idx == `DCNT_IDX_RXE_DATA) begin
      adv_word = st_ff.rxerr_data;
    end
    if (idx == `DCNT_IDX_RXE_IDLE) begin
      adv_word = st_ff.rxerr_idle;
    end
  endfunction : adv_word

  // Next state of the whole block.
  always_comb begin
    nxt_st = st_ff;
    // Bus response one cycle after setup, read data and error captured with it.
    nxt_st.apb_st = setup ? DCNT_ST_RESP : DCNT_ST_IDLE;
    nxt_st.apb_err = setup && !is_mapped(I_PADDR);
    if (setup) begin
      nxt_st.prdata  = '0;
      if (!I_PWRITE) begin
        case (I_PADDR)
          `DCNT_OFF_CTRL: begin
            nxt_st.prdata[`DCNT_CTRL_LOOP] = st_ff.loopback;
          end
          `DCNT_OFF_STAT: begin
            nxt_st.prdata[`DCNT_STAT_LINK]    = st_ff.link_up;
            nxt_st.prdata[`DCNT_STAT_ANDONE]  = st_ff.an_done;
            nxt_st.prdata[`DCNT_STAT_XOVER_A] = st_ff.crossover_pair_a_result;
            nxt_st.prdata[`DCNT_STAT_XOVER_B] = st_ff.crossover_pair_b_result;
            nxt_st.prdata[`DCNT_STAT_POL_LSB +: 4] = pol_old;
            nxt_st.prdata[`DCNT_STAT_C1_VLD]  = st_ff.an_done;
            nxt_st.prdata[`DCNT_STAT_C023_VLD] = st_ff.link_up;
            nxt_st.prdata[`DCNT_STAT_LOOP]    = st_ff.loopback;
          end
          `DCNT_OFF_IRQ_STAT: begin
            nxt_st.prdata[3:0] = st_ff.irq_stat;
          end
          `DCNT_OFF_IRQ_MASK: begin
            nxt_st.prdata[3:0] = st_ff.irq_mask;
          end
          `DCNT_OFF_ADV_ADDR: begin
            nxt_st.prdata[4:0] = st_ff.adv_idx;
          end
          `DCNT_OFF_ADV_DATA: begin
            nxt_st.prdata[15:0] = adv_word(st_ff.adv_idx);
          end
          default: begin
            nxt_st.prdata = '0;
          end
        endcase
      end
    end
    // Register writes; status and data port are read-only.
    if (wr_en) begin
      case (I_PADDR)
        `DCNT_OFF_CTRL:     nxt_st.loopback = I_PWDATA[`DCNT_CTRL_LOOP];
        `DCNT_OFF_IRQ_MASK: nxt_st.irq_mask = I_PWDATA[3:0];
        `DCNT_OFF_ADV_ADDR: nxt_st.adv_idx  = I_PWDATA[4:0];
        default:            nxt_st.adv_idx  = st_ff.adv_idx;
      endcase
    end
    // Sampled line status and per-channel inversion flags.
    nxt_st.link_up = I_LINK_UP;
    nxt_st.an_done = I_AN_DONE;
    nxt_st.crossover_pair_a_result = I_CROSSOVER_PAIR_A_RESULT;
    nxt_st.crossover_pair_b_result = I_CROSSOVER_PAIR_B_RESULT;
    nxt_st.chan0_inverted_flag = pol_now[0];
    nxt_st.chan1_inverted_flag = pol_now[1];
    nxt_st.chan2_inverted_flag = pol_now[2];
    nxt_st.chan3_inverted_flag = pol_now[3];
    // Sticky interrupt status, an event in the clearing cycle wins.
    nxt_st.irq_stat = (st_ff.irq_stat & ~irq_clr) | irq_ev;
    nxt_st.irq = |(nxt_st.irq_stat & nxt_st.irq_mask);
    // Saturating receive error counters.
    if (I_RXERR_DATA && (st_ff.rxerr_data != `DCNT_SAT16)) begin
      nxt_st.rxerr_data = st_ff.rxerr_data + 16'h0001;
    end
    if (I_RXERR_IDLE && (st_ff.rxerr_idle != `DCNT_SAT16)) begin
      nxt_st.rxerr_idle = st_ff.rxerr_idle + 16'h0001;
    end
    // Loopback path: scrambler output to descrambler, line silent and powered down.
    nxt_st.descr_rx   = st_ff.loopback ? I_SCR_TX_DATA : I_LINE_RX_DATA;
    nxt_st.line_tx    = st_ff.loopback ? 8'h00 : I_SCR_TX_DATA;
    nxt_st.line_tx_en = !st_ff.loopback && I_TX_VALID;
    nxt_st.tx_pwr_en  = !st_ff.loopback;
  end

  // State register; counters and control at zero after reset.
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      st_ff          <= '0;
      st_ff.irq_mask <= `DCNT_IRQ_MASK_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the state register.
  assign O_PRDATA        = st_ff.prdata;
  assign O_PREADY        = st_ff.apb_st == DCNT_ST_RESP;
  assign O_PSLVERR       = st_ff.apb_err;
  assign O_LINE_TX_DATA  = st_ff.line_tx;
  assign O_LINE_TX_EN    = st_ff.line_tx_en;
  assign O_TX_PWR_EN     = st_ff.tx_pwr_en;
  assign O_DESCR_RX_DATA = st_ff.descr_rx;
  assign O_POL_CORRECT   = pol_old;
  assign O_IRQ           = st_ff.irq;

  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_ARST_N);

  chk_loop_route: assert property (st_ff.loopback && $stable(st_ff.loopback) |=>
                                   O_DESCR_RX_DATA == $past(I_SCR_TX_DATA))
    else $error("Loopback data not routed to descrambler.");
  chk_loop_quiet: assert property (st_ff.loopback |=>
                                   !O_TX_PWR_EN && !O_LINE_TX_EN && O_LINE_TX_DATA == 8'h00)
    else $error("Line driven during loopback.");
  chk_apb_ready: assert property (setup |=> O_PREADY ##1 (!O_PREADY || $past(setup)))
    else $error("Ready not exactly one cycle after setup.");
  chk_rxerr_step: assert property (I_RXERR_DATA && st_ff.rxerr_data != `DCNT_SAT16 |=>
                                   st_ff.rxerr_data == $past(st_ff.rxerr_data) + 16'h1)
    else $error("Data receive error not counted.");
  chk_idle_step: assert property (I_RXERR_IDLE && st_ff.rxerr_idle != `DCNT_SAT16 |=>
                                  st_ff.rxerr_idle == $past(st_ff.rxerr_idle) + 16'h1)
    else $error("Idle receive error not counted.");
  chk_adv_strobe: assert property (adv_rd && st_ff.adv_idx == `DCNT_IDX_GOOD_LO |->
                                   ctr_rd_lo == 3'b001 && ctr_rd_hi == 3'b000)
    else $error("Wrong counter strobed on low read.");
  chk_irq_level: assert property (##1 O_IRQ == |(st_ff.irq_stat & st_ff.irq_mask))
    else $error("Interrupt output disagrees with status and mask.");
  chk_pol_report: assert property (1'b1 |=> O_POL_CORRECT == $past(I_CHAN_POL_DETECT))
    else $error("Polarity flags not tracking detector.");

  // Status word carries the sampled crossover, polarity and validity fields.
  chk_stat_xover: assert property (setup && !I_PWRITE && I_PADDR == `DCNT_OFF_STAT |=>
      O_PRDATA[`DCNT_STAT_XOVER_B -: 2] ==
      $past({st_ff.crossover_pair_b_result, st_ff.crossover_pair_a_result}))
    else $error("Crossover fields wrong in status word.");
  chk_stat_pol: assert property (setup && !I_PWRITE && I_PADDR == `DCNT_OFF_STAT |=>
      O_PRDATA[`DCNT_STAT_POL_LSB +: 4] == $past(pol_old))
    else $error("Polarity flags wrong in status word.");
  chk_stat_valid: assert property (setup && !I_PWRITE && I_PADDR == `DCNT_OFF_STAT |=>
      O_PRDATA[`DCNT_STAT_C1_VLD] == $past(st_ff.an_done) &&
      O_PRDATA[`DCNT_STAT_C023_VLD] == $past(st_ff.link_up))
    else $error("Validity bits wrong in status word.");

  // Error flag follows the decoded address; a control write lands at completion.
  chk_bus_err: assert property (setup |=> O_PSLVERR == !is_mapped($past(I_PADDR)))
    else $error("Bus error flag wrong for address.");
  chk_ctrl_write: assert property (wr_en && I_PADDR == `DCNT_OFF_CTRL |=>
      st_ff.loopback == $past(I_PWDATA[`DCNT_CTRL_LOOP]))
    else $error("Loopback control bit not written.");

  // Sticky status keeps its bits until cleared and takes every event.
  chk_irq_sticky: assert property (irq_clr == 4'h0 |=>
      (st_ff.irq_stat & $past(st_ff.irq_stat)) == $past(st_ff.irq_stat))
    else $error("Status bit lost without a clear.");
  chk_irq_event: assert property (irq_ev != 4'h0 |=>
      (st_ff.irq_stat & $past(irq_ev)) == $past(irq_ev))
    else $error("Event did not set its status bit.");

  // Normal path when loopback is off.
  chk_line_path: assert property (!st_ff.loopback |=>
      O_DESCR_RX_DATA == $past(I_LINE_RX_DATA))
    else $error("Line data not routed to descrambler.");
  chk_line_drive: assert property (!st_ff.loopback |=> O_TX_PWR_EN &&
      O_LINE_TX_EN == $past(I_TX_VALID) && O_LINE_TX_DATA == $past(I_SCR_TX_DATA))
    else $error("Line not driven outside loopback.");

  // Data-port reads strobe only the addressed slice.
  chk_crc_strobe: assert property (adv_rd && st_ff.adv_idx == `DCNT_IDX_CRC_LO |->
      ctr_rd_lo == 3'b010 && ctr_rd_hi == 3'b000)
    else $error("Wrong counter strobed on error low read.");
  chk_tx_hi_strobe: assert property (adv_rd &&
      st_ff.adv_idx == `DCNT_IDX_TX_LO + `DCNT_IDX_HI_STEP |->
      ctr_rd_hi == 3'b100 && ctr_rd_lo == 3'b000)
    else $error("Wrong counter strobed on transmit high read.");
endmodule : dcnt_top
`default_nettype wire

//--- hw/dcnt_regs.svh
// Register offsets, field positions, reset values and indexes of the link diagnostics block.
// Assumes inclusion by its bare name from the top module, the host model and the bench.
// Functional notes
// - Loopback control bit routes scrambler output straight into descrambler input.
// - In loopback nothing goes to the line and line transmitters power down.
// - Crossover result is reported as two fields, pair 0:1 and pair 2:3.
// - Polarity inversion is detected, corrected and reported per channel, four bits.
// - Channel 1 inversion flag is valid only once auto-negotiation has completed.
// - Channel 0, 2 and 3 inversion flags are valid only while link is up.
// - Good received packets are counted in 48 bits, read as low, mid, high.
// - Reading good-packet low word snapshots mid and high; low is read first.
// - Reading good-packet high word last clears its live count (the snapshot stays); an event in that cycle counts as one.
// - CRC errors are counted in 48 bits, read as low, mid and high words.
// - CRC low read latches mid and high; the high read clears the counter.
// - Receive errors during packet data are counted in one 16-bit register.
// - Receive errors during idle are counted in a separate 16-bit register.
// - Transmitted packets are counted in 48 bits, read as low, mid, high.
// - Transmit low read latches mid and high; the high read clears it.
// - Counters are read-only, reached through an address port and read-data port.
`ifndef DCNT_REGS_SVH
`define DCNT_REGS_SVH
// Byte offsets on the register bus.
`define DCNT_OFF_CTRL     12'h000
`define DCNT_OFF_STAT     12'h004
`define DCNT_OFF_IRQ_STAT 12'h008
`define DCNT_OFF_IRQ_MASK 12'h00C
`define DCNT_OFF_ADV_ADDR 12'h010
`define DCNT_OFF_ADV_DATA 12'h014
// Control and status field positions.
`define DCNT_CTRL_LOOP    0
`define DCNT_STAT_LINK    0
`define DCNT_STAT_ANDONE  1
`define DCNT_STAT_XOVER_A 2
`define DCNT_STAT_XOVER_B 3
`define DCNT_STAT_POL_LSB 4
`define DCNT_STAT_C1_VLD  8
`define DCNT_STAT_C023_VLD 9
`define DCNT_STAT_LOOP    10
// Interrupt event bits.
`define DCNT_EV_LINK      0
`define DCNT_EV_ANDONE    1
`define DCNT_EV_XOVER     2
`define DCNT_EV_POL       3
`define DCNT_IRQ_MASK_RST 4'h0
// Indexes of the indirect counter words.
`define DCNT_IDX_GOOD_LO  5'h00
`define DCNT_IDX_CRC_LO   5'h03
`define DCNT_IDX_RXE_DATA 5'h06
`define DCNT_IDX_RXE_IDLE 5'h07
`define DCNT_IDX_TX_LO    5'h08
`define DCNT_IDX_HI_STEP  5'h02
`define DCNT_IDX_MID_STEP 5'h01
`define DCNT_SAT16        16'hFFFF
`endif

//--- hw/dcnt_pkg.sv
// Types shared by the link diagnostics block and its counter slices.
// Assumes the constants header sits beside it.
`default_nettype none
package dcnt_pkg;
  typedef logic [15:0] dcnt_word_t;
  typedef logic [47:0] dcnt_cnt48_t;
  typedef logic [11:0] dcnt_addr_t;
  typedef logic [31:0] dcnt_data_t;
  typedef logic [4:0]  dcnt_idx_t;

  // Bus response phase of the register slave.
  typedef enum logic {DCNT_ST_IDLE, DCNT_ST_RESP} dcnt_apb_st_t;

  // State of one 48-bit counter slice.
  typedef struct packed {
    dcnt_cnt48_t cnt;
    logic [31:0] snap;
  } dcnt_ctr_st_t;
endpackage : dcnt_pkg
`default_nettype wire

//--- hw/dcnt_ctr_if.sv
// Signals between the top module and one 48-bit counter slice.
// Assumes a single clock shared by both ends.
`default_nettype none
interface dcnt_ctr_if;
  import dcnt_pkg::*;
  logic       inc;
  logic       rd_lo;
  logic       rd_hi;
  dcnt_word_t lo;
  dcnt_word_t mid;
  dcnt_word_t hi;
  modport ctr  (input inc, rd_lo, rd_hi, output lo, mid, hi);
  modport user (output inc, rd_lo, rd_hi, input lo, mid, hi);
endinterface : dcnt_ctr_if
`default_nettype wire

//--- hw/dcnt_ctr48.sv
// One 48-bit statistics counter with a snapshot taken on the low-word read.
// Assumes read strobes are one-cycle pulses from the top module.
`default_nettype none
module dcnt_ctr48 (
  input wire logic i_clk,
  input wire logic i_arst_n,
  dcnt_ctr_if.ctr  bus
);
  import dcnt_pkg::*;

  dcnt_ctr_st_t st_ff;
  dcnt_ctr_st_t nxt_st;

  // Next state: snapshot on the low read, clear on the high read, count always.
  always_comb begin
    nxt_st = st_ff;
    if (bus.rd_lo) begin
      nxt_st.snap = st_ff.cnt[47:16];
    end
    if (bus.rd_hi) begin
      nxt_st.cnt = {47'h0000_0000_0000, bus.inc};
    end else if (bus.inc) begin
      nxt_st.cnt = st_ff.cnt + 48'h0000_0000_0001;
    end
  end

  // State register, zero after reset.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Low word is live; mid and high come from the snapshot.
  assign bus.lo  = st_ff.cnt[15:0];
  assign bus.mid = st_ff.snap[15:0];
  assign bus.hi  = st_ff.snap[31:16];

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  chk_lo_latch_snap: assert property (bus.rd_lo |=> st_ff.snap == $past(st_ff.cnt[47:16]))
    else $error("Snapshot not taken on low read.");
  chk_hi_read_clear: assert property (bus.rd_hi |=> st_ff.cnt == {47'h0, $past(bus.inc)})
    else $error("Counter not cleared by high read.");
  chk_snap_hold: assert property (!bus.rd_lo |=> $stable(st_ff.snap))
    else $error("Snapshot changed without low read.");
  chk_count_step: assert property (bus.inc && !bus.rd_hi |=>
                                   st_ff.cnt == $past(st_ff.cnt) + 48'h1)
    else $error("Counter missed an event.");
endmodule : dcnt_ctr48
`default_nettype wire

//--- dv/dcnt_host_model.sv
// Register-bus host model: issues APB transfers and indirect counter reads.
// Assumes one clock and a slave that raises pready in the access phase.
`default_nettype none
`include "dcnt_regs.svh"
module dcnt_host_model import dcnt_pkg::*; (
  input  wire logic           i_clk,
  input  wire logic           i_pready,
  input  wire dcnt_pkg::dcnt_data_t i_prdata,
  input  wire logic           i_pslverr,
  output var  logic           o_psel,
  output var  logic           o_penable,
  output var  logic           o_pwrite,
  output var  dcnt_pkg::dcnt_addr_t o_paddr,
  output var  dcnt_pkg::dcnt_data_t o_pwdata
);
  timeunit 1ns;
  timeprecision 1ps;

  // The bus idles from time zero.
  initial begin
    o_psel    = 1'h0;
    o_penable = 1'h0;
    o_pwrite  = 1'h0;
    o_paddr   = 12'h000;
    o_pwdata  = 32'h0000_0000;
  end

  // One transfer: setup, then access held until pready is sampled high.
  task automatic xfer(input logic w, input dcnt_addr_t a, input dcnt_data_t wd,
                      output dcnt_data_t rd, output logic err);
    @(posedge i_clk);
    o_psel    <= 1'h1;
    o_penable <= 1'h0;
    o_pwrite  <= w;
    o_paddr   <= a;
    o_pwdata  <= wd;
    @(posedge i_clk);
    o_penable <= 1'h1;
    do begin
      @(posedge i_clk);
    end while (i_pready !== 1'h1);
    rd = i_prdata;
    err = i_pslverr;
    o_psel    <= 1'h0;
    o_penable <= 1'h0;
  endtask : xfer

  // Indirect read: the address port is written, then the data port read.
  task automatic adv_rd(input dcnt_idx_t idx, output dcnt_data_t rd);
    logic e;
    dcnt_data_t d;
    xfer(1'h1, `DCNT_OFF_ADV_ADDR, 32'(idx), d, e);
    xfer(1'h0, `DCNT_OFF_ADV_DATA, 32'h0000_0000, rd, e);
  endtask : adv_rd
endmodule : dcnt_host_model
`default_nettype wire

//--- dv/dcnt_top_tb.sv
// Self-checking bench of the link diagnostics block.
// Assumes the host model drives the register bus and the bench drives the rest.
`default_nettype none
`include "dcnt_regs.svh"
module dcnt_top_tb import dcnt_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk, arst_n, psel, penable, pwrite, pready, pslverr;
  dcnt_addr_t paddr;
  dcnt_data_t pwdata, prdata;
  logic [7:0] scr = 8'h00, lrx = 8'h00, ltx, drx;
  logic       txv = 1'h0, ltxen, pwr, irq;
  logic       link = 1'h0, an = 1'h0, xa = 1'h0, xb = 1'h0;
  logic [3:0] pol = 4'h0, polc;
  logic [4:0] ev = 5'h00;
  int         err_total = 0;
  int         checks = 0;

  dcnt_top dcnt_top_inst (.I_SYS_CLK(clk), .I_ARST_N(arst_n), .I_PSEL(psel),
    .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_SCR_TX_DATA(scr),
    .I_TX_VALID(txv), .I_LINE_RX_DATA(lrx), .O_LINE_TX_DATA(ltx), .O_LINE_TX_EN(ltxen),
    .O_TX_PWR_EN(pwr), .O_DESCR_RX_DATA(drx), .I_LINK_UP(link), .I_AN_DONE(an),
    .I_CROSSOVER_PAIR_A_RESULT(xa), .I_CROSSOVER_PAIR_B_RESULT(xb),
    .I_CHAN_POL_DETECT(pol), .O_POL_CORRECT(polc), .I_GOOD_PKT(ev[0]),
    .I_CRC_ERR(ev[1]), .I_TX_PKT(ev[2]), .I_RXERR_DATA(ev[3]), .I_RXERR_IDLE(ev[4]),
    .O_IRQ(irq));

  dcnt_host_model dcnt_host_model_inst (.i_clk(clk), .i_pready(pready),
    .i_prdata(prdata), .i_pslverr(pslverr), .o_psel(psel), .o_penable(penable),
    .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata));

  // Prints the counts and the verdict, then ends the run.
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run

  // Compares one value and reports a mismatch at once.
  task automatic chk(input dcnt_data_t got, input dcnt_data_t exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Sends n one-cycle pulses on event line k.
  task automatic pulse(input int k, input int n);
    repeat (n) begin
      @(posedge clk);
      ev[k] <= 1'h1;
      @(posedge clk);
      ev[k] <= 1'h0;
    end
  endtask : pulse

  // Plain register access through the host model.
  task automatic reg_io(input logic w, input dcnt_addr_t a, input dcnt_data_t wd,
                        output dcnt_data_t rd, output logic e);
    dcnt_host_model_inst.xfer(w, a, wd, rd, e);
  endtask : reg_io

  // Reset state, the mask reset value and an unmapped address.
  task automatic t_reset;
    dcnt_data_t d;
    logic e;
    @(negedge clk);
    chk(32'(pwr), 32'h0000_0001);
    reg_io(1'h0, `DCNT_OFF_IRQ_MASK, 32'h0000_0000, d, e);
    chk(d, 32'h0000_0000);
    reg_io(1'h0, 12'h020, 32'h0000_0000, d, e);
    chk({d[30:0], e}, 32'h0000_0001);
    $display("Test reset done");
  endtask : t_reset

  // Each 48-bit counter: reset zero, count, snapshot, clear by the high read.
  task automatic t_counters;
    dcnt_data_t d;
    dcnt_idx_t  b[3] = '{`DCNT_IDX_GOOD_LO, `DCNT_IDX_CRC_LO, `DCNT_IDX_TX_LO};
    for (int k = 0; k < 3; k++) begin
      dcnt_host_model_inst.adv_rd(b[k], d);
      chk(d, 32'h0000_0000);
      pulse(k, k + 2);
      dcnt_host_model_inst.adv_rd(b[k], d);
      chk(d, 32'(k + 2));
      pulse(k, 1);
      dcnt_host_model_inst.adv_rd(b[k] + `DCNT_IDX_MID_STEP, d);
      chk(d, 32'h0000_0000);
      dcnt_host_model_inst.adv_rd(b[k] + `DCNT_IDX_HI_STEP, d);
      chk(d, 32'h0000_0000);
      dcnt_host_model_inst.adv_rd(b[k], d);
      chk(d, 32'h0000_0000);
    end
    $display("Test counters done");
  endtask : t_counters

  // Receive-error counters are separate 16-bit registers.
  task automatic t_rxerr;
    dcnt_data_t d;
    pulse(3, 3);
    pulse(4, 2);
    dcnt_host_model_inst.adv_rd(`DCNT_IDX_RXE_DATA, d);
    chk(d, 32'h0000_0003);
    dcnt_host_model_inst.adv_rd(`DCNT_IDX_RXE_IDLE, d);
    chk(d, 32'h0000_0002);
    $display("Test receive errors done");
  endtask : t_rxerr

  // Loopback on, then off, with data on both paths.
  task automatic t_loop;
    dcnt_data_t d;
    logic e;
    @(posedge clk);
    scr <= 8'hA5;
    lrx <= 8'h3C;
    txv <= 1'h1;
    reg_io(1'h1, `DCNT_OFF_CTRL, 32'h0000_0001, d, e);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk(32'(drx), 32'h0000_00A5);
    chk({ltx, 6'h00, ltxen, pwr}, 32'h0000_0000);
    reg_io(1'h1, `DCNT_OFF_CTRL, 32'h0000_0000, d, e);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk(32'(drx), 32'h0000_003C);
    chk({ltx, 6'h00, ltxen, pwr}, 32'h0000_A503);
    $display("Test loopback done");
  endtask : t_loop

  // Crossover, polarity and validity qualifiers in the status word.
  task automatic t_status;
    dcnt_data_t d;
    logic e;
    @(posedge clk);
    link <= 1'h1;
    an <= 1'h1;
    xa <= 1'h1;
    pol <= 4'hA;
    repeat (3) @(posedge clk);
    reg_io(1'h0, `DCNT_OFF_STAT, 32'h0000_0000, d, e);
    chk(d, 32'h0000_03A7);
    chk(32'(polc), 32'h0000_000A);
    link <= 1'h0;
    an <= 1'h0;
    xb <= 1'h1;
    repeat (3) @(posedge clk);
    reg_io(1'h0, `DCNT_OFF_STAT, 32'h0000_0000, d, e);
    chk(d, 32'h0000_00AC);
    $display("Test status done");
  endtask : t_status

  // Sticky events, masking and write-one-to-clear.
  task automatic t_irq;
    dcnt_data_t d;
    logic e;
    reg_io(1'h0, `DCNT_OFF_IRQ_STAT, 32'h0000_0000, d, e);
    chk(d, 32'h0000_000F);
    chk(32'(irq), 32'h0000_0000);
    reg_io(1'h1, `DCNT_OFF_IRQ_MASK, 32'h0000_0001, d, e);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(32'(irq), 32'h0000_0001);
    reg_io(1'h1, `DCNT_OFF_IRQ_STAT, 32'h0000_0001, d, e);
    reg_io(1'h0, `DCNT_OFF_IRQ_STAT, 32'h0000_0000, d, e);
    chk(d, 32'h0000_000E);
    @(negedge clk);
    chk(32'(irq), 32'h0000_0000);
    $display("Test interrupt done");
  endtask : t_irq

  // Clock of 5 ns period.
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  // Watchdog cuts a hang short.
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    complete_run();
  end

  // Reset for 20 cycles, then every scenario in turn.
  initial begin
    arst_n = 1'h0;
    repeat (20) @(posedge clk);
    arst_n <= 1'h1;
    @(posedge clk);
    t_reset();
    t_counters();
    t_rxerr();
    t_loop();
    t_status();
    t_irq();
    complete_run();
  end
endmodule : dcnt_top_tb
`default_nettype wire
